// ---- hw/obc_debounce_clk.sv ----
// module: debounce clock tick generator, period = selected debounce time / 8
module obc_debounce_clk #(
  parameter int UNIT_CYCLES = obc_pkg::DEB_UNIT_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // control
  input wire logic [2:0] deb_code_i,
  // tick out
  output logic tick_o
);

  // units of 1 us per debounce clock period: 0,1,2,4..64 for codes 0..7
  function automatic logic [6:0] units_of(input logic [2:0] code);
    units_of = (code == obc_pkg::DEB_CODE_NONE) ? 7'h00 : 7'(7'h01 << (code - 3'h1));
  endfunction

  logic [15:0] unit_cnt;
  logic [6:0] unit_idx;
  logic [2:0] last_code;
  logic [15:0] next_unit_cnt;
  logic [6:0] next_unit_idx;
  logic next_tick;

  // ----------------------------------------------------------------
  // divider: restart whenever the code changes so no stale period leaks
  // ----------------------------------------------------------------
  always_comb begin
    next_unit_cnt = unit_cnt + 16'h0001;
    next_unit_idx = unit_idx;
    next_tick = 1'b0;
    if (deb_code_i != last_code) begin
      next_unit_cnt = 16'h0000;
      next_unit_idx = 7'h00;
    end else if (deb_code_i == obc_pkg::DEB_CODE_NONE) begin
      next_unit_cnt = 16'h0000;
      next_tick = 1'b1;  // zero debounce: clock runs every cycle
    end else if (unit_cnt == 16'(UNIT_CYCLES - 1)) begin
      next_unit_cnt = 16'h0000;
      if (unit_idx == units_of(deb_code_i) - 7'h01) begin
        next_unit_idx = 7'h00;
        next_tick = 1'b1;  // period = units * 1 us = time / 8
      end else begin
        next_unit_idx = unit_idx + 7'h01;
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      unit_cnt <= 16'h0000;
      unit_idx <= 7'h00;
      last_code <= 3'h0;
      tick_o <= 1'b0;
    end else begin
      unit_cnt <= next_unit_cnt;
      unit_idx <= next_unit_idx;
      last_code <= deb_code_i;
      tick_o <= next_tick;
    end
  end

  // ----------------------------------------------------------------
  // checks: spacing of ticks under a stable code
  // ----------------------------------------------------------------
  logic [31:0] gap;
  logic seen;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gap <= 32'h0;
      seen <= 1'b0;
    end else if (deb_code_i != last_code) begin
      gap <= 32'h0;
      seen <= 1'b0;
    end else if (tick_o) begin
      gap <= 32'h0;
      seen <= 1'b1;
    end else begin
      gap <= gap + 32'h1;
    end
  end

  chk_tick_period: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (tick_o && seen && deb_code_i != obc_pkg::DEB_CODE_NONE && $stable(deb_code_i))
    |-> (gap + 32'h1 == 32'(UNIT_CYCLES) * 32'(units_of(deb_code_i))))
    else $error("debounce tick period wrong");

endmodule

// ---- hw/obc_pkg.sv ----
// package: register map, field layout, reset values and timing for the bias control slice
package obc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] DRV_CFG_ADDR = 8'h2C;   // headset_driver_config
  localparam logic [7:0] RSVD_ADDR = 8'h2D;      // reserved_analog_slot
  localparam logic [7:0] BIAS_ADDR = 8'h2E;      // mic_bias_control

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int DEB_MSB = 7;           // debounce code, driver register
  localparam int DEB_LSB = 5;
  localparam int LINE_MODE_BIT = 2;     // driver mode, driver register
  localparam int SW_PD_BIT = 7;         // software power-down, bias register
  localparam int OVERRIDE_BIT = 3;      // headset override, bias register
  localparam int LEVEL_MSB = 1;         // bias level, bias register
  localparam int LEVEL_LSB = 0;
  localparam logic [7:0] DRV_CFG_RST = 8'h00;
  localparam logic [7:0] BIAS_RST = 8'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // ----------------------------------------------------------------
  // timing: debounce clock period is debounce time / 8
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int DEB_UNIT_PS = 1000000;   // 1 us: period of the 8 us code
  localparam int DEB_UNIT_CYCLES = DEB_UNIT_PS / CLK_PERIOD_PS;
  localparam int DEB_DIVIDE = 8;
  localparam logic [2:0] DEB_CODE_NONE = 3'h0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BIAS_OFF = 2'b00,
    BIAS_2V0 = 2'b01,
    BIAS_2V5 = 2'b10,
    BIAS_SUPPLY = 2'b11
  } obc_bias_type;

  typedef struct packed {
    logic line_mode;           // headphone_output_driver: 0 headphone, 1 line out
    logic sw_powerdown;        // device software power-down
    obc_bias_type bias_level;  // microphone_bias_output, after headset gating
    logic [2:0] deb_code;      // headset short-circuit debounce code
  } obc_analog_type;

  localparam obc_analog_type ANALOG_RST = '{1'b0, 1'b0, BIAS_OFF, 3'h0};

endpackage

// ---- hw/obc_regs.sv ----
// module: output driver, debounce and microphone bias control registers
//
// Function
// - driver mode bit 0 selects headphone driver, 1 selects line output driver
// - debounce logic clock period is one eighth of the debounce time
// - bias register bit 7 set enters software power-down, clear keeps it off
// - override 0 keeps bias off when detection on and no headset; 1 powers it
// - bias level: 00 off, 01 2 V, 10 2.5 V, 11 analog supply rail
// - three-bit debounce code selects 0,8,16,32,64,128,256,512 us
module obc_regs #(
  parameter int UNIT_CYCLES = obc_pkg::DEB_UNIT_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // headset detection status
  input wire logic headset_detect_en_i,
  input wire logic headset_present_i,
  // analog controls
  output obc_pkg::obc_analog_type analog_o,
  output logic debounce_tick_o
);

  // ----------------------------------------------------------------
  // headset presence comes from a pin: two-flop synchroniser
  // ----------------------------------------------------------------
  logic present_meta;
  logic present_sync;
  logic next_present_meta;
  logic next_present_sync;

  always_comb begin
    next_present_meta = headset_present_i;
    next_present_sync = present_meta;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      present_meta <= 1'b0;
      present_sync <= 1'b0;
    end else begin
      present_meta <= next_present_meta;
      present_sync <= next_present_sync;
    end
  end

  // ----------------------------------------------------------------
  // register storage and read port
  // ----------------------------------------------------------------
  logic [7:0] drv_cfg;
  logic [7:0] bias_cfg;
  logic [7:0] next_drv_cfg;
  logic [7:0] next_bias_cfg;
  logic [7:0] next_rdata;

  // writes land whole; reserved bits are stored as written and read back
  always_comb begin
    next_drv_cfg = drv_cfg;
    next_bias_cfg = bias_cfg;
    next_rdata = reg_rdata_o;
    if (reg_wr_i) begin
      case (reg_addr_i)
        obc_pkg::DRV_CFG_ADDR: next_drv_cfg = reg_wdata_i;
        obc_pkg::BIAS_ADDR: next_bias_cfg = reg_wdata_i;
        // the reserved slot has no storage, so a stray write cannot disturb
        // analog trim behind it
        default: next_drv_cfg = drv_cfg;
      endcase
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        obc_pkg::DRV_CFG_ADDR: next_rdata = drv_cfg;
        obc_pkg::BIAS_ADDR: next_rdata = bias_cfg;
        default: next_rdata = obc_pkg::RDATA_RST;
      endcase
    end
  end

  // fields hold until rewritten or reset
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      drv_cfg <= obc_pkg::DRV_CFG_RST;
      bias_cfg <= obc_pkg::BIAS_RST;
      reg_rdata_o <= obc_pkg::RDATA_RST;
    end else begin
      drv_cfg <= next_drv_cfg;
      bias_cfg <= next_bias_cfg;
      reg_rdata_o <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // analog control levels, registered so the analog side sees no glitch
  // ----------------------------------------------------------------
  obc_pkg::obc_analog_type next_analog;
  logic bias_gated;

  always_comb begin
    // bias withheld while detection waits for a headset
    bias_gated = !bias_cfg[obc_pkg::OVERRIDE_BIT] && headset_detect_en_i && !present_sync;
    next_analog.line_mode = drv_cfg[obc_pkg::LINE_MODE_BIT];
    next_analog.sw_powerdown = bias_cfg[obc_pkg::SW_PD_BIT];
    next_analog.deb_code = drv_cfg[obc_pkg::DEB_MSB:obc_pkg::DEB_LSB];
    if (bias_gated) begin
      next_analog.bias_level = obc_pkg::BIAS_OFF;
    end else begin
      // level code passes straight to the bias generator
      next_analog.bias_level =
        obc_pkg::obc_bias_type'(bias_cfg[obc_pkg::LEVEL_MSB:obc_pkg::LEVEL_LSB]);
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      analog_o <= obc_pkg::ANALOG_RST;
    end else begin
      analog_o <= next_analog;
    end
  end

  // ----------------------------------------------------------------
  // debounce clock derived from the selected debounce time
  // ----------------------------------------------------------------
  logic deb_tick;

  obc_debounce_clk #(
    .UNIT_CYCLES(UNIT_CYCLES)
  ) u_deb_clk (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .deb_code_i(analog_o.deb_code),
    .tick_o(deb_tick)
  );

  // extra stage keeps the output straight from a flop at the top boundary
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      debounce_tick_o <= 1'b0;
    end else begin
      debounce_tick_o <= deb_tick;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_line_mode_follow: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (reg_wr_i && reg_addr_i == obc_pkg::DRV_CFG_ADDR)
    |-> ##2 (analog_o.line_mode == $past(reg_wdata_i[obc_pkg::LINE_MODE_BIT], 2)))
    else $error("driver mode does not follow write");

  chk_sw_powerdown: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (reg_wr_i && reg_addr_i == obc_pkg::BIAS_ADDR)
    |-> ##2 (analog_o.sw_powerdown == $past(reg_wdata_i[obc_pkg::SW_PD_BIT], 2)))
    else $error("software power-down does not follow write");

  chk_bias_gated_off: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (!bias_cfg[obc_pkg::OVERRIDE_BIT] && headset_detect_en_i && !present_sync)
    |=> (analog_o.bias_level == obc_pkg::BIAS_OFF))
    else $error("bias powered without headset");

  chk_bias_override: assert property (@(posedge clk_i) disable iff (!resetn_i)
    bias_cfg[obc_pkg::OVERRIDE_BIT]
    |=> (analog_o.bias_level == $past(bias_cfg[obc_pkg::LEVEL_MSB:obc_pkg::LEVEL_LSB])))
    else $error("override did not power bias");

  chk_bias_level_sel: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (reg_wr_i && reg_addr_i == obc_pkg::BIAS_ADDR && reg_wdata_i[obc_pkg::OVERRIDE_BIT])
    |-> ##2 (analog_o.bias_level == $past(reg_wdata_i[obc_pkg::LEVEL_MSB:obc_pkg::LEVEL_LSB], 2)))
    else $error("bias level does not match field");

  chk_deb_code: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (reg_wr_i && reg_addr_i == obc_pkg::DRV_CFG_ADDR)
    |-> ##2 (analog_o.deb_code == $past(reg_wdata_i[obc_pkg::DEB_MSB:obc_pkg::DEB_LSB], 2)))
    else $error("debounce code does not follow write");

  chk_fields_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (!reg_wr_i || reg_addr_i == obc_pkg::RSVD_ADDR)
    |=> ($stable(drv_cfg) && $stable(bias_cfg)))
    else $error("register changed without a write");

  chk_rdata_drv_cfg: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (reg_rd_i && reg_addr_i == obc_pkg::DRV_CFG_ADDR)
    |=> (reg_rdata_o == $past(drv_cfg)))
    else $error("driver register read back wrong");

  chk_rdata_bias_cfg: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (reg_rd_i && reg_addr_i == obc_pkg::BIAS_ADDR)
    |=> (reg_rdata_o == $past(bias_cfg)))
    else $error("bias register read back wrong");

  // the reserved slot keeps nothing, so it reads as zero like any unmapped offset
  chk_rdata_unmapped: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (reg_rd_i && reg_addr_i != obc_pkg::DRV_CFG_ADDR && reg_addr_i != obc_pkg::BIAS_ADDR)
    |=> (reg_rdata_o == obc_pkg::RDATA_RST))
    else $error("unmapped offset read not zero");

  // read data stands until the next read strobe
  chk_rdata_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (!reg_rd_i)
    |=> $stable(reg_rdata_o))
    else $error("read data changed without a read");

  // without gating the programmed level code reaches the bias generator untouched
  chk_bias_level_pass: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !(!bias_cfg[obc_pkg::OVERRIDE_BIT] && headset_detect_en_i && !present_sync)
    |=> (analog_o.bias_level == $past(bias_cfg[obc_pkg::LEVEL_MSB:obc_pkg::LEVEL_LSB])))
    else $error("bias level not passed through");

  // zero debounce time: the debounce clock runs on every cycle, two stages behind the code
  chk_tick_every_cycle: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (analog_o.deb_code == obc_pkg::DEB_CODE_NONE && $stable(analog_o.deb_code))
    |-> ##2 debounce_tick_o)
    else $error("debounce clock idle at zero debounce");

  // driver fields are static while the driver register holds still
  chk_drv_fields_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $stable(drv_cfg)
    |=> $stable({analog_o.line_mode, analog_o.deb_code}))
    else $error("driver field moved without a write");

endmodule

// ---- testbench/test_obc_regs.sv ----
// testbench: random and corner-case checks of the bias control register slice
module test_obc_regs;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int UNIT = 4;  // shortened debounce unit keeps tick periods brief
  logic clk_i;
  logic resetn_i;
  logic [7:0] reg_addr_i;
  logic [7:0] reg_wdata_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [7:0] reg_rdata_o;
  logic headset_detect_en_i;
  logic headset_present_i;
  obc_pkg::obc_analog_type analog_o;
  logic debounce_tick_o;
  logic [7:0] drv_s;
  logic [7:0] bias_s;
  logic [31:0] seed;
  int miscompares;
  int num_checks;

  obc_regs #(.UNIT_CYCLES(UNIT)) i_dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .headset_detect_en_i(headset_detect_en_i),
    .headset_present_i(headset_present_i), .analog_o(analog_o),
    .debounce_tick_o(debounce_tick_o));

  // ----------------------------------------------------------------
  // clock, helpers and compare tasks
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  // expected analog levels: bias is gated off only without override and headset
  function automatic obc_pkg::obc_analog_type expect_analog();
    obc_pkg::obc_analog_type e;
    e.line_mode = drv_s[2];
    e.sw_powerdown = bias_s[7];
    e.bias_level = obc_pkg::obc_bias_type'(bias_s[1:0]);
    if (!bias_s[3] && headset_detect_en_i && !headset_present_i) begin
      e.bias_level = obc_pkg::BIAS_OFF;
    end
    e.deb_code = drv_s[7:5];
    return e;
  endfunction

  task automatic check_byte(input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic check_ana(input obc_pkg::obc_analog_type exp);
    num_checks++;
    if (analog_o !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, analog_o);
    end
  endtask

  task automatic check_cnt(input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // ----------------------------------------------------------------
  // register port tasks, inputs change on the falling edge
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
    if (a == obc_pkg::DRV_CFG_ADDR) drv_s = d;
    if (a == obc_pkg::BIAS_ADDR) bias_s = d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    @(negedge clk_i);
    d = reg_rdata_o;
  endtask

  // settle the present synchroniser, then compare outputs and read back all three offsets
  task automatic check_state();
    logic [7:0] d;
    repeat (5) @(negedge clk_i);
    check_ana(expect_analog());
    rd(obc_pkg::DRV_CFG_ADDR, d);
    check_byte(drv_s, d);
    rd(obc_pkg::BIAS_ADDR, d);
    check_byte(bias_s, d);
    rd(obc_pkg::RSVD_ADDR, d);
    check_byte(8'h00, d);
  endtask

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] n;
    logic [7:0] corner [6];
    resetn_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    headset_detect_en_i = 1'b0;
    headset_present_i = 1'b0;
    drv_s = 8'h00;
    bias_s = 8'h00;
    seed = 32'h0401;
    miscompares = 0;
    num_checks = 0;
    corner = '{8'h03, 8'h02, 8'h0A, 8'h89, 8'h81, 8'h8B};
    repeat (6) @(negedge clk_i);
    resetn_i = 1'b1;
    check_state();
    $display("test reset_values done");
    // bias levels with and without override, detection on, headset absent then present
    wr(obc_pkg::DRV_CFG_ADDR, 8'hE4);
    for (int i = 0; i < 12; i++) begin
      headset_detect_en_i = 1'b1;
      headset_present_i = i[0];
      if (i[0] == 1'b0) wr(obc_pkg::BIAS_ADDR, corner[i / 2]);
      check_state();
    end
    $display("test bias_gating done");
    // random traffic, unmapped offsets included; reserved slot, bias reserved bits and driver bits 1:0 left alone
    for (int i = 0; i < 40; i++) begin
      seed = xorshift(seed);
      headset_detect_en_i = seed[16];
      headset_present_i = seed[17];
      case (seed[9:8])
        2'h0: wr(obc_pkg::DRV_CFG_ADDR, seed[7:0] & 8'hFC);
        2'h1: wr(obc_pkg::BIAS_ADDR, seed[7:0] & 8'h8B);
        2'h2: wr(8'h2B, seed[7:0]);  // slot 0x2D is never written
        default: wr(8'h2F, seed[7:0]);
      endcase
      check_state();
    end
    $display("test random_access done");
    // debounce tick period per code: every cycle for 0, else unit times 2^(k-1)
    for (int k = 0; k < 8; k++) begin
      wr(obc_pkg::DRV_CFG_ADDR, {k[2:0], 5'h00});
      repeat (10) @(negedge clk_i);
      n = 16'h0;
      while (debounce_tick_o !== 1'b1 && n < 16'd600) begin
        @(negedge clk_i);
        n++;
      end
      n = 16'h0;
      do begin
        @(negedge clk_i);
        n++;
      end while (debounce_tick_o !== 1'b1 && n < 16'd600);
      check_cnt((k == 0) ? 16'h0001 : 16'(UNIT << (k - 1)), n);
    end
    $display("test debounce_tick done");
    // reset in mid-run brings every field back to its reset value
    @(negedge clk_i);
    resetn_i = 1'b0;
    drv_s = obc_pkg::DRV_CFG_RST;
    bias_s = obc_pkg::BIAS_RST;
    repeat (2) @(negedge clk_i);
    resetn_i = 1'b1;
    check_state();
    $display("test second_reset done");
    report_and_stop();
  end

  // watchdog: the whole sequence needs well under 20 us
  initial begin
    #100us;
    miscompares++;
    report_and_stop();
  end
endmodule
